// ### rtl/adc_output_ctrl.v
// Function
// - Divide sample clock by one, two, four
// - Clock may run four times rated rate
// - Serial mode: power-down by register or pin
// - Pin mode: power-down pin high powers down
// - Releasing power-down pin resumes conversion
// - Powered down: data drivers high impedance
// - Standby via serial keeps reference, wakes after a fixed delay
// - Wake delay grows with time powered down
// - Strap selects output format in pin mode
// - Serial mode: offset, twos or gray format
// - Config field assigns output-disable to mode pin
// - Output-disable pin high tristates data, clock
// - Nine conversion cycles of pipeline latency
// - Data valid at data clock rising edge, falling edge when inverted
// - Thirteen output bits: sample plus overrange
// - Offset binary codes; twos inverts top bit
// - Overrange set and code saturated beyond limits
`timescale 1ns/100ps
`include "adc_out_consts.vh"

module adc_output_ctrl #(
   parameter SAMPLE_W = `SAMPLE_W,
   parameter LATENCY = `LATENCY,
   parameter WAKE_CNT_W = `WAKE_CNT_W,
   parameter [`WAKE_CNT_W-1:0] WAKE_BASE = `WAKE_BASE,
   parameter [`WAKE_CNT_W-1:0] STANDBY_WAKE = `STANDBY_WAKE
) (
   input wire ref_clk, // Sample clock input
   input wire rst, // Synchronous reset, active high
   input wire serialMode, // Serial port in use
   input wire [1:0] divSel, // Clock divider select
   input wire spiPowerDown, // Register power-down command
   input wire spiStandby, // Register standby command
   input wire [1:0] modeFunc, // Mode pin function field
   input wire modePin, // External mode pin
   input wire power_down_pin, // Power-down pin, pin mode
   input wire format_select_strap, // Format strap, pin mode
   input wire [1:0] spiFormat, // Register output format
   input wire dataClkInvert, // Data clock polarity invert
   input wire [`IN_W-1:0] sampleIn, // Input, signed half-LSB units
   output reg [SAMPLE_W-1:0] dataOut_q, // Sample data
   output reg overRange_q, // Overrange bit
   output reg dataOe_q, // Data and overrange drive enable
   output reg data_clock_output_q, // Data clock
   output reg dataClkOe_q, // Data clock drive enable
   output reg running_q // Converter running
);

   // Power and output control

   reg [`ST_W-1:0] state_q;
   reg [`ST_W-1:0] state_d;
   reg [WAKE_CNT_W-1:0] downCnt_q;
   reg [WAKE_CNT_W-1:0] downCnt_d;
   reg [WAKE_CNT_W-1:0] wakeCnt_q;
   reg [WAKE_CNT_W-1:0] wakeCnt_d;
   reg standbyOnly_q;
   reg standbyOnly_d;
   reg strapDone_q;
   reg strapFmt_q;
   reg [2:0] halfLen;

   wire pinPowerDown;
   wire modePowerDown;
   wire modeOutDisable;
   wire powerDownReq;
   wire standbyReq;
   wire sleepReq;
   wire outDisable;
   wire convEn;
   wire midEn;
   wire run;
   wire [WAKE_CNT_W-1:0] wakeLoad;
   wire [WAKE_CNT_W-1:0] one;

   assign one = {{(WAKE_CNT_W-1){1'b0}}, 1'b1};

   // Strap level is held from reset release, so capture after it
   always @(posedge ref_clk) begin
      if (rst) begin
         strapDone_q <= 1'b0;
         strapFmt_q <= 1'b0;
      end else if (!strapDone_q) begin
         strapDone_q <= 1'b1;
         strapFmt_q <= format_select_strap;
      end
   end

   assign pinPowerDown = !serialMode && power_down_pin;
   assign modePowerDown = serialMode && modePin &&
      (modeFunc == `MODE_FN_POWER_DOWN);
   assign modeOutDisable = serialMode && modePin &&
      (modeFunc == `MODE_FN_OUT_DISABLE);

   assign powerDownReq = pinPowerDown || modePowerDown ||
      (serialMode && spiPowerDown);
   assign standbyReq = serialMode && spiStandby && !powerDownReq;
   assign sleepReq = powerDownReq || standbyReq;
   assign outDisable = modeOutDisable;

   // Longer sleep drains more charge, so recovery scales with it
   assign wakeLoad = standbyOnly_q ? STANDBY_WAKE :
      WAKE_BASE + (downCnt_q >> `WAKE_SHIFT);

   always @* begin
      state_d = state_q;
      downCnt_d = downCnt_q;
      wakeCnt_d = wakeCnt_q;
      standbyOnly_d = standbyOnly_q;
      case (state_q)
         `ST_RUN: begin
            if (sleepReq) begin
               state_d = `ST_DOWN;
               downCnt_d = {WAKE_CNT_W{1'b0}};
               standbyOnly_d = standbyReq;
            end
         end
         `ST_DOWN: begin
            if (downCnt_q != {WAKE_CNT_W{1'b0}} - one) begin
               downCnt_d = downCnt_q + one;
            end
            if (powerDownReq) begin
               standbyOnly_d = 1'b0;
            end
            if (!sleepReq) begin
               state_d = `ST_WAKE;
               wakeCnt_d = wakeLoad;
            end
         end
         `ST_WAKE: begin
            if (sleepReq) begin
               // Wake progress is dropped; down count resumes from its old value
               state_d = `ST_DOWN;
               standbyOnly_d = standbyReq && standbyOnly_q;
            end else if (wakeCnt_q == {WAKE_CNT_W{1'b0}}) begin
               state_d = `ST_RUN;
            end else begin
               wakeCnt_d = wakeCnt_q - one;
            end
         end
         default: begin
            state_d = `ST_RUN;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         state_q <= `ST_RUN;
         downCnt_q <= {WAKE_CNT_W{1'b0}};
         wakeCnt_q <= {WAKE_CNT_W{1'b0}};
         standbyOnly_q <= 1'b0;
      end else begin
         state_q <= state_d;
         downCnt_q <= downCnt_d;
         wakeCnt_q <= wakeCnt_d;
         standbyOnly_q <= standbyOnly_d;
      end
   end

   // A request halts conversion at once, before the state register moves
   assign run = (state_q == `ST_RUN) && !sleepReq;

   // Clock divider

   always @* begin
      if (divSel == `DIV_SEL_4) begin
         halfLen = `HALF_4;
      end else if (divSel == `DIV_SEL_2) begin
         halfLen = `HALF_2;
      end else if (divSel == `DIV_SEL_1) begin
         halfLen = `HALF_1;
      end else begin
         // Unused select code falls back to the undivided rate
         halfLen = `HALF_1;
      end
   end

   rate_divider u_div (
      .refClk(ref_clk),
      .rst(rst),
      .run(run),
      .halfLen(halfLen),
      .convEn(convEn),
      .midEn(midEn)
   );

   // Sample coding

   reg [SAMPLE_W-1:0] code;
   reg lowOver;
   reg highOver;
   wire [`IN_W-1:0] shifted;

   assign shifted = sampleIn + `IN_OFFSET;

   // Limits sit half an LSB beyond each end code
   always @* begin
      lowOver = $signed(sampleIn) < $signed(`IN_NEG_LIMIT);
      highOver = $signed(sampleIn) > $signed(`IN_POS_LIMIT);
   end

   always @* begin
      if (shifted[`IN_W-1]) begin
         code = `CODE_MIN;
      end else if (shifted[`IN_W-2:SAMPLE_W+1] != 1'b0) begin
         code = `CODE_MAX;
      end else begin
         code = shifted[SAMPLE_W:1];
      end
      if (lowOver) begin
         code = `CODE_MIN;
      end else if (highOver) begin
         code = `CODE_MAX;
      end
   end

   // Pipeline; it freezes while stopped, so held samples survive a sleep

   wire overFlag;
   wire [`WORD_W-1:0] pipeIn;
   wire [`WORD_W-1:0] pipeOut;

   assign overFlag = lowOver || highOver;
   assign pipeIn = {overFlag, code};

   sample_pipe #(
      .W(`WORD_W),
      .DEPTH(LATENCY)
   ) u_pipe (
      .refClk(ref_clk),
      .rst(rst),
      .adv(convEn),
      .din(pipeIn),
      .dout(pipeOut)
   );

   // Output formatting, applied late so a format change acts at the next conversion edge

   reg [1:0] fmt;
   reg [SAMPLE_W-1:0] formatted;
   wire [SAMPLE_W-1:0] obCode;
   wire [SAMPLE_W-1:0] grayCode;

   assign obCode = pipeOut[SAMPLE_W-1:0];
   assign grayCode[SAMPLE_W-1] = obCode[SAMPLE_W-1];

   genvar b;
   generate
      for (b = 0; b < SAMPLE_W - 1; b = b + 1) begin : g_gray
         assign grayCode[b] = obCode[b] ^ obCode[b+1];
      end
   endgenerate

   always @* begin
      if (serialMode) begin
         fmt = spiFormat;
      end else if (strapFmt_q) begin
         fmt = `FMT_TWOS;
      end else begin
         fmt = `FMT_OFFSET;
      end
      case (fmt)
         `FMT_TWOS: begin
            formatted = obCode ^ `MSB_MASK;
         end
         `FMT_GRAY: begin
            formatted = grayCode;
         end
         `FMT_OFFSET: begin
            formatted = obCode;
         end
         default: begin
            // Unused code 3 reads as offset binary
            formatted = obCode;
         end
      endcase
   end

   // Output registers

   reg [SAMPLE_W-1:0] dataOut_d;
   reg overRange_d;
   reg dataClk_d;
   wire powerOff;
   wire driveOn;

   // Standby keeps drivers on; standby asked for during power-down stays dark
   assign powerOff = powerDownReq || (state_q == `ST_DOWN && !standbyOnly_q);
   assign driveOn = !powerOff && !outDisable;

   always @* begin
      dataOut_d = dataOut_q;
      overRange_d = overRange_q;
      if (convEn) begin
         dataOut_d = formatted;
         overRange_d = pipeOut[`WORD_W-1];
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         dataOut_q <= `CODE_MIN;
         overRange_q <= 1'b0;
      end else begin
         dataOut_q <= dataOut_d;
         overRange_q <= overRange_d;
      end
   end

   // Data changes as the clock goes to the dataClkInvert level, so the opposite edge finds it settled
   always @* begin
      dataClk_d = data_clock_output_q;
      if (!run) begin
         dataClk_d = dataClkInvert;
      end else if (convEn) begin
         dataClk_d = dataClkInvert;
      end else if (midEn) begin
         dataClk_d = !dataClkInvert;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         data_clock_output_q <= 1'b0;
      end else begin
         data_clock_output_q <= dataClk_d;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         dataOe_q <= 1'b0;
         dataClkOe_q <= 1'b0;
         running_q <= 1'b0;
      end else begin
         dataOe_q <= driveOn;
         dataClkOe_q <= driveOn;
         running_q <= run;
      end
   end

endmodule // adc_output_ctrl

// ### rtl/adc_out_consts.vh
`ifndef ADC_OUT_CONSTS_VH
`define ADC_OUT_CONSTS_VH

// Divider select codes and the resulting half-period in ref_clk cycles
`define DIV_SEL_1 2'h0
`define DIV_SEL_2 2'h1
`define DIV_SEL_4 2'h2
`define HALF_1 3'h1
`define HALF_2 3'h2
`define HALF_4 3'h4
`define DIV_CNT_W 4

// Output number formats under serial control
`define FMT_OFFSET 2'h0
`define FMT_TWOS 2'h1
`define FMT_GRAY 2'h2

// Mode pin function field (bits 6:5 of config register 0x08)
`define MODE_FN_POWER_DOWN 2'h0
`define MODE_FN_OUT_DISABLE 2'h1

// Sample path
`define SAMPLE_W 12
`define WORD_W 13
`define LATENCY 9
`define IN_W 15
`define IN_OFFSET 15'h1000
`define IN_NEG_LIMIT 15'h6fff
`define IN_POS_LIMIT 15'h0fff
`define CODE_MIN 12'h000
`define CODE_MAX 12'hfff
`define MSB_MASK 12'h800

// Wake-up timing, in ref_clk cycles
`define WAKE_CNT_W 16
`define WAKE_SHIFT 4
`define WAKE_BASE 16'h0004
`define STANDBY_WAKE 16'h0010

// Power state machine, one-hot
`define ST_W 3
`define ST_RUN 3'h1
`define ST_DOWN 3'h2
`define ST_WAKE 3'h4

`endif

// ### rtl/rate_divider.v
`timescale 1ns/100ps
`include "adc_out_consts.vh"

module rate_divider (
   input wire refClk, // Block clock
   input wire rst, // Synchronous reset, active high
   input wire run, // Converter running
   input wire [2:0] halfLen, // Half conversion period in cycles
   output wire convEn, // Conversion edge pulse
   output wire midEn // Mid-period pulse
);

   reg [`DIV_CNT_W-1:0] cnt_q;
   wire [`DIV_CNT_W-1:0] periodM1;

   assign periodM1 = {halfLen, 1'b0} - {{(`DIV_CNT_W-1){1'b0}}, 1'b1};

   // A ratio change mid-period never strands the count past its end
   always @(posedge refClk) begin
      if (rst || !run) begin
         cnt_q <= {`DIV_CNT_W{1'b0}};
      end else if (cnt_q >= periodM1) begin
         cnt_q <= {`DIV_CNT_W{1'b0}};
      end else begin
         cnt_q <= cnt_q + {{(`DIV_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign convEn = run && (cnt_q == {`DIV_CNT_W{1'b0}});
   assign midEn = run && (cnt_q == {1'b0, halfLen});

endmodule // rate_divider

// ### rtl/sample_pipe.v
`timescale 1ns/100ps

module sample_pipe #(
   parameter W = 13,
   parameter DEPTH = 9
) (
   input wire refClk, // Block clock
   input wire rst, // Synchronous reset, active high
   input wire adv, // Advance one conversion step
   input wire [W-1:0] din, // New word
   output wire [W-1:0] dout // Oldest word
);

   reg [W-1:0] stage [0:DEPTH-1];

   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
         always @(posedge refClk) begin
            if (rst) begin
               stage[i] <= {W{1'b0}};
            end else if (adv) begin
               stage[i] <= (i == 0) ? din : stage[(i == 0) ? 0 : i - 1];
            end
         end
      end
   endgenerate

   assign dout = stage[DEPTH-1];

endmodule // sample_pipe

// ### tb/adc_output_ctrl_asserts.sv
`timescale 1ns/100ps
`include "adc_out_consts.vh"
module adc_output_ctrl_asserts (
   input wire ref_clk, // Clock
   input wire rst, // Reset
   input wire serialMode, // Serial control
   input wire spiPowerDown, // Reg sleep
   input wire spiStandby, // Reg standby
   input wire [1:0] modeFunc, // Pin function
   input wire modePin, // Mode pin
   input wire power_down_pin, // Sleep pin
   input wire dataClkInvert, // Clock invert
   input wire [11:0] dataOut_q, // Code
   input wire overRange_q, // Overrange
   input wire dataOe_q, // Data enable
   input wire data_clock_output_q, // Data clock
   input wire dataClkOe_q, // Clock enable
   input wire running_q // Running
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   AST_PIN_PD: assert property (
      !serialMode && power_down_pin |=> !running_q && !dataOe_q && !dataClkOe_q)
      else $error("pin sleep left outputs on");
   AST_SPI_PD: assert property (
      serialMode && spiPowerDown |=> !running_q && !dataOe_q)
      else $error("register sleep ignored");
   AST_MODE_PD: assert property (
      serialMode && modeFunc == `MODE_FN_POWER_DOWN && modePin |=> !running_q)
      else $error("mode pin sleep ignored");
   AST_OEB_HIGH: assert property (
      serialMode && modeFunc == `MODE_FN_OUT_DISABLE && modePin |=> !dataOe_q && !dataClkOe_q)
      else $error("output disable ignored");
   AST_OEB_LOW: assert property (
      (serialMode && modeFunc == `MODE_FN_OUT_DISABLE && !modePin && !spiPowerDown
         && !spiStandby) [*3] |-> dataOe_q && dataClkOe_q)
      else $error("outputs not enabled");
   AST_STANDBY: assert property (
      (serialMode && spiStandby && !spiPowerDown && !modePin) [*3] |-> dataOe_q && !running_q)
      else $error("standby state wrong");
   AST_FROZEN: assert property (
      !running_q |-> $stable(dataOut_q) && $stable(overRange_q))
      else $error("data moved while stopped");
   AST_DCO_HOLD: assert property (
      (!running_q) [*2] |-> data_clock_output_q == $past(dataClkInvert))
      else $error("data clock ran while stopped");
   AST_LAUNCH: assert property (
      $changed(dataOut_q) || $changed(overRange_q) |-> data_clock_output_q == $past(dataClkInvert))
      else $error("data changed off launch edge");
   AST_OR_END: assert property (
      overRange_q |-> dataOut_q inside {12'h000, 12'hfff, 12'h800, 12'h7ff})
      else $error("overrange code not saturated");
endmodule // adc_output_ctrl_asserts

// ### tb/capture_model.sv
`timescale 1ns/100ps
module capture_model (
   input wire data_clock_output, // Data clock
   input wire inv, // Clock polarity
   input wire oe, // Bus driven
   input wire [11:0] data, // Code bus
   input wire ovr, // Overrange line
   output reg [12:0] capWord, // Last word
   output reg [31:0] capCount // Captures seen
);
   initial begin
      capWord = 13'h0000;
      capCount = 32'h0;
   end
   // Capture on the edge away from the launch level; a floating bus is ignored
   always @(posedge data_clock_output or negedge data_clock_output) begin
      if (data_clock_output != inv && oe) begin
         capWord <= {ovr, data};
         capCount <= capCount + 32'h1;
      end
   end
endmodule // capture_model

// ### tb/adc_output_and_power_control_bench.sv
`timescale 1ns/100ps
module adc_output_and_power_control_bench;
   reg ref_clk, rst, serialMode, spiPowerDown, spiStandby, modePin, power_down_pin;
   reg format_select_strap, dataClkInvert;
   reg [1:0] divSel, modeFunc, spiFormat;
   reg [14:0] sampleIn;
   wire [11:0] dataOut_q;
   wire overRange_q, dataOe_q, data_clock_output_q, dataClkOe_q, running_q;
   wire [12:0] capWord;
   wire [31:0] capCount;
   integer err_total = 0, checks_done = 0, cyc = 0, n, t, p, i, wS, wL, wB;
   adc_output_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .serialMode(serialMode),
      .divSel(divSel), .spiPowerDown(spiPowerDown), .spiStandby(spiStandby),
      .modeFunc(modeFunc), .modePin(modePin), .power_down_pin(power_down_pin),
      .format_select_strap(format_select_strap), .spiFormat(spiFormat),
      .dataClkInvert(dataClkInvert), .sampleIn(sampleIn), .dataOut_q(dataOut_q),
      .overRange_q(overRange_q), .dataOe_q(dataOe_q), .data_clock_output_q(data_clock_output_q),
      .dataClkOe_q(dataClkOe_q), .running_q(running_q));
   capture_model far (.data_clock_output(data_clock_output_q), .inv(dataClkInvert), .oe(dataOe_q),
      .data(dataOut_q), .ovr(overRange_q), .capWord(capWord), .capCount(capCount));
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   task tick(input integer k);
      begin
         repeat (k) @(posedge ref_clk);
         #2;
      end
   endtask
   task chk(input [12:0] got, input [12:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task cap;
      begin
         n = capCount;
         t = 0;
         while (capCount == n && t < 50) begin
            tick(1);
            t = t + 1;
         end
      end
   endtask
   task code(input [14:0] x, input [12:0] exp);
      begin
         sampleIn = x;
         tick(100);
         cap;
         chk(capWord, exp);
      end
   endtask
   task per(input [1:0] s, input [12:0] exp);
      begin
         divSel = s;
         tick(100);
         cap;
         p = cyc;
         cap;
         chk(cyc - p, exp);
      end
   endtask
   task sleep(input integer hold, input sb, output integer w);
      begin
         spiStandby = sb;
         power_down_pin = !sb;
         tick(hold);
         chk({dataClkOe_q, dataOe_q, running_q}, {sb, sb, 1'b0});
         spiStandby = 0;
         power_down_pin = 0;
         w = 0;
         while (running_q !== 1'b1 && w < 600) begin
            tick(1);
            w = w + 1;
         end
      end
   endtask
   task reset(input s);
      begin
         rst = 1;
         format_select_strap = s;
         tick(4);
         rst = 0;
         tick(1);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total = err_total + 1;
      final_report;
   end
   initial begin
      {serialMode, spiPowerDown, spiStandby, modePin, power_down_pin, dataClkInvert} = 6'h0;
      {divSel, modeFunc, spiFormat} = 6'h0;
      sampleIn = 15'h0000;
      reset(0);
      code(15'h0ffe, 13'h0fff);
      code(15'h0000, 13'h0800);
      code(15'h6ffe, 13'h1000);
      code(15'h1000, 13'h1fff);
      sampleIn = 15'h7000;
      i = 0;
      while (capWord !== 13'h0000 && i < 30) begin
         cap;
         i = i + 1;
      end
      chk(i, 10);
      $display("pin codes done");
      per(0, 2);
      per(1, 4);
      per(2, 8);
      per(3, 2);
      divSel = 0;
      $display("divider done");
      sleep(10, 0, wS);
      sleep(400, 0, wL);
      chk(wS < wL, 1);
      reset(1);
      code(15'h0000, 13'h0000);
      code(15'h7000, 13'h0800);
      serialMode = 1;
      modeFunc = 1;
      for (i = 0; i < 4; i = i + 1) begin
         spiFormat = i;
         code(15'h034a, i == 1 ? 13'h01a5 : i == 2 ? 13'h0d77 : 13'h09a5);
      end
      spiFormat = 0;
      dataClkInvert = 1;
      code(15'h034a, 13'h09a5);
      dataClkInvert = 0;
      $display("serial formats done");
      modePin = 1;
      tick(2);
      chk({dataClkOe_q, dataOe_q, running_q}, 3'h1);
      modePin = 0;
      tick(3);
      chk({dataClkOe_q, dataOe_q, running_q}, 3'h7);
      modeFunc = 0;
      modePin = 1;
      tick(2);
      chk(running_q, 0);
      modePin = 0;
      spiPowerDown = 1;
      tick(2);
      chk({dataClkOe_q, dataOe_q, running_q}, 3'h0);
      spiPowerDown = 0;
      while (running_q !== 1'b1) tick(1);
      sleep(400, 1, wB);
      chk(wB < wL, 1);
      code(15'h034a, 13'h09a5);
      $display("power control done");
      final_report;
   end
endmodule // adc_output_and_power_control_bench
bind adc_output_ctrl adc_output_ctrl_asserts chk_i (.ref_clk(ref_clk), .rst(rst),
   .serialMode(serialMode), .spiPowerDown(spiPowerDown), .spiStandby(spiStandby),
   .modeFunc(modeFunc), .modePin(modePin), .power_down_pin(power_down_pin),
   .dataClkInvert(dataClkInvert), .dataOut_q(dataOut_q), .overRange_q(overRange_q),
   .dataOe_q(dataOe_q), .data_clock_output_q(data_clock_output_q),
   .dataClkOe_q(dataClkOe_q), .running_q(running_q));
